//--- rtl/adspi_pkg.sv
package adspi_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [4:0] ADR_SYSTEM_CONTROL    = 5'h00;
   localparam logic [4:0] ADR_HALF_BRIDGE_OUT   = 5'h01;
   localparam logic [4:0] ADR_HIGH_SIDE_OUT     = 5'h02;
   localparam logic [4:0] ADR_HB_STATUS_CTL     = 5'h03;
   localparam logic [4:0] ADR_HS_STATUS_CTL     = 5'h04;
   localparam logic [4:0] ADR_HALL_STATUS_CTL   = 5'h07;
   localparam logic [4:0] ADR_ANALOG_MUX_CTL    = 5'h08;
   localparam logic [4:0] ADR_INTERRUPT_MASK    = 5'h09;
   localparam logic [4:0] ADR_INTERRUPT_FLAGS   = 5'h0A;
   localparam logic [4:0] ADR_WATCHDOG_CONTROL  = 5'h0B;
   localparam logic [4:0] ADR_SYSTEM_STATUS     = 5'h0C;
   localparam logic [4:0] ADR_RESET_CAUSE       = 5'h0D;
   localparam logic [4:0] ADR_TRIM_ONE          = 5'h0F;
   localparam logic [4:0] ADR_TRIM_THREE        = 5'h11;
   localparam int         NUM_REGS              = 18;
   // ****************************************
   // field layout
   // ****************************************
   localparam int         WD_EN_BIT             = 7;
   localparam int         WD_PER_HI             = 6;
   localparam int         WD_PER_LO             = 5;
   localparam int         WD_RESTART_BIT        = 0;
   localparam logic [7:0] SYSTEM_CONTROL_READ_MASK      = 8'h9F;
   localparam logic [7:0] REG_RESET             = 8'h00;
   localparam logic [1:0] WD_PER_RESET          = 2'h0;
   // ****************************************
   // frame layout and timing
   // ****************************************
   localparam int         FRAME_BITS            = 16;
   localparam int         PARITY_IDX            = 6;
   localparam int         CLK_HZ                = 25000000;
   localparam int         WD_MIN_PERIOD_MS      = 10;
   localparam int         WD_MIN_PERIOD_CYC     =
      WD_MIN_PERIOD_MS * (CLK_HZ / 1000);
endpackage : adspi_pkg

//--- rtl/adspi_port.sv
module adspi_port
   import adspi_pkg::*;
#(
   parameter int WD_BASE_CYC = WD_MIN_PERIOD_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       serial_shift_clock_i,
   input  wire logic       select_n_i,
   input  wire logic       mosi_i,
   input  wire logic [7:0] system_status_i,
   input  wire logic [7:0] interrupt_flags_i,
   input  wire logic [7:0] reset_cause_i,
   input  wire logic       stop_mode_i,
   input  wire logic       sleep_mode_i,
   output logic            miso_o,
   output logic            miso_oe_n_o,
   output logic            reg_wr_stb_o,
   output logic [4:0]      reg_wr_addr_o,
   output logic [7:0]      reg_wr_data_o,
   output logic            watchdog_enable_once_o,
   output logic [1:0]      watchdog_period_select_o,
   output logic            watchdog_sysrst_o
);
   import adspi_pkg::*;

   // ****************************************
   // decode helpers
   // ****************************************
   // storage exists for read-write and mixed registers
   function automatic logic is_stored(input logic [4:0] a);
      is_stored = (a <= ADR_HS_STATUS_CTL) ||
                  (a == ADR_HALL_STATUS_CTL) ||
                  (a == ADR_INTERRUPT_MASK) ||
                  (a == ADR_TRIM_ONE);
   endfunction : is_stored

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [2:0] sck_s_r;
   logic [2:0] ssn_s_r;
   logic [1:0] mosi_s_r;

   // two flops per pin, third stage only for edges
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_s_r  <= 3'h0;
         ssn_s_r  <= 3'h7;
         mosi_s_r <= 2'h0;
      end else begin
         sck_s_r  <= {sck_s_r[1:0], serial_shift_clock_i};
         ssn_s_r  <= {ssn_s_r[1:0], select_n_i};
         mosi_s_r <= {mosi_s_r[0], mosi_i};
      end
   end

   logic sel;
   logic sel_fall;
   logic sel_rise;
   logic sck_rise;
   logic sck_fall;

   assign sel      = ~ssn_s_r[1];
   assign sel_fall = ~ssn_s_r[1] & ssn_s_r[2];
   assign sel_rise = ssn_s_r[1] & ~ssn_s_r[2];
   assign sck_rise = sel & sck_s_r[1] & ~sck_s_r[2];
   assign sck_fall = sel & ~sck_s_r[1] & sck_s_r[2];

   // ****************************************
   // frame shifting
   // ****************************************
   logic [15:0] rx_r;
   logic [4:0]  fcnt_r;
   logic [4:0]  rcnt_r;
   logic [7:0]  stat_r;
   logic [7:0]  data_r;
   logic        miso_r;
   logic        oe_n_r;

   // sample master bits on clock fall, count them
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_r   <= 16'h0000;
         fcnt_r <= 5'h00;
      end else if (sel_fall) begin
         fcnt_r <= 5'h00;
      end else if (sck_fall) begin
         rx_r <= {rx_r[14:0], mosi_s_r[1]};
         if (fcnt_r != 5'h11) begin
            fcnt_r <= fcnt_r + 5'h01;
         end
      end
   end

   // current value of an addressed register
   logic [7:0] mem_r [NUM_REGS];
   logic       wd_en_r;
   logic [1:0] wd_per_r;

   function automatic logic [7:0] rd_val(input logic [4:0] a);
      rd_val = 8'h00;
      if (a == ADR_SYSTEM_CONTROL) begin
         rd_val = mem_r[0] & SYSTEM_CONTROL_READ_MASK;
      end else if (is_stored(a)) begin
         rd_val = mem_r[a];
      end else if (a == ADR_INTERRUPT_FLAGS) begin
         rd_val = interrupt_flags_i;
      end else if (a == ADR_WATCHDOG_CONTROL) begin
         rd_val[WD_EN_BIT] = wd_en_r;
         rd_val[WD_PER_HI:WD_PER_LO] = wd_per_r;
      end else if (a == ADR_SYSTEM_STATUS) begin
         rd_val = system_status_i;
      end else if (a == ADR_RESET_CAUSE) begin
         rd_val = reset_cause_i;
      end
   endfunction : rd_val

   // status at frame start, register while parity shifts
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stat_r <= 8'h00;
         data_r <= 8'h00;
      end else if (sel_fall) begin
         stat_r <= system_status_i;
      end else if (sck_fall && fcnt_r == 5'(PARITY_IDX)) begin
         data_r <= rd_val(rx_r[4:0]);
      end
   end

   // drive next bit on clock rise
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rcnt_r <= 5'h00;
         miso_r <= 1'b0;
      end else if (sel_fall) begin
         rcnt_r <= 5'h00;
         miso_r <= 1'b0;
      end else if (sck_rise) begin
         if (rcnt_r < 5'h08) begin
            miso_r <= stat_r[3'(3'h7 - rcnt_r[2:0])];
         end else if (rcnt_r < 5'h10) begin
            miso_r <= data_r[3'(3'h7 - rcnt_r[2:0])];
         end else begin
            miso_r <= 1'b0;
         end
         if (rcnt_r != 5'h11) begin
            rcnt_r <= rcnt_r + 5'h01;
         end
      end
   end

   // output enable follows select
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         oe_n_r <= 1'b1;
      end else begin
         oe_n_r <= ~sel;
      end
   end

   assign miso_o      = miso_r;
   assign miso_oe_n_o = oe_n_r;

   // ****************************************
   // frame end and register write
   // ****************************************
   logic       frame_ok;
   logic       is_write;
   logic       par_ok;
   logic       do_write;
   logic [4:0] waddr;
   logic [7:0] wdata;

   assign frame_ok = sel_rise && fcnt_r == 5'(FRAME_BITS);
   assign is_write = ~rx_r[15];
   assign par_ok   = ~(^rx_r[15:9]);
   assign waddr    = rx_r[14:10];
   assign wdata    = rx_r[7:0];
   assign do_write = frame_ok & is_write & par_ok;

   // plain storage registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            mem_r[i] <= REG_RESET;
         end
      end else if (do_write && is_stored(waddr)) begin
         mem_r[waddr] <= wdata;
      end
   end

   // write strobe to the rest of the die
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_wr_stb_o  <= 1'b0;
         reg_wr_addr_o <= 5'h00;
         reg_wr_data_o <= 8'h00;
      end else begin
         reg_wr_stb_o <= do_write;
         if (do_write) begin
            reg_wr_addr_o <= waddr;
            reg_wr_data_o <= wdata;
         end
      end
   end

   // ****************************************
   // watchdog
   // ****************************************
   logic        wd_wr;
   logic        wd_kick;
   logic        stop_d_r;
   logic        sleep_d_r;
   logic [23:0] wd_cnt_r;
   logic [23:0] wd_period;
   logic        wd_closed;
   logic        wd_fire;

   assign wd_wr   = do_write && waddr == ADR_WATCHDOG_CONTROL;
   assign wd_kick = wd_wr & wdata[WD_RESTART_BIT];
   assign wd_period = 24'(WD_BASE_CYC) << (2'h3 - wd_per_r);
   assign wd_closed = wd_cnt_r < (wd_period >> 1);
   assign wd_fire = wd_en_r & ~stop_mode_i &
                    ((wd_kick & wd_closed) ||
                     wd_cnt_r >= wd_period - 24'h000001);

   // enable sets once, period select stored
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wd_en_r  <= 1'b0;
         wd_per_r <= WD_PER_RESET;
      end else begin
         if (sleep_mode_i && !sleep_d_r) begin
            wd_en_r <= 1'b0;
         end else if (wd_wr && wdata[WD_EN_BIT]) begin
            wd_en_r <= 1'b1;
         end
         if (wd_wr) begin
            wd_per_r <= wdata[WD_PER_HI:WD_PER_LO];
         end
      end
   end

   // mode edge history
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_d_r  <= 1'b0;
         sleep_d_r <= 1'b0;
      end else begin
         stop_d_r  <= stop_mode_i;
         sleep_d_r <= sleep_mode_i;
      end
   end

   // window timer
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wd_cnt_r <= 24'h000000;
      end else if (!wd_en_r || wd_fire || wd_kick) begin
         wd_cnt_r <= 24'h000000;
      end else if (stop_d_r && !stop_mode_i) begin
         wd_cnt_r <= 24'h000000;
      end else if (!stop_mode_i) begin
         wd_cnt_r <= wd_cnt_r + 24'h000001;
      end
   end

   // system reset pulse
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         watchdog_sysrst_o <= 1'b0;
      end else begin
         watchdog_sysrst_o <= wd_fire;
      end
   end

   assign watchdog_enable_once_o   = wd_en_r;
   assign watchdog_period_select_o = wd_per_r;

   // ****************************************
   // checks
   // ****************************************
   float_idle_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ssn_s_r[1] |=> miso_oe_n_o)
      else $error("output driven while deselected");

   drive_frame_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      sel_fall |=> !miso_oe_n_o)
      else $error("output not driven after select fall");

   bit_change_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !sck_rise && !sel_fall |=> $stable(miso_o))
      else $error("output changed without clock rise");

   status_first_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      sck_rise && rcnt_r == 5'h00 |=> miso_o == stat_r[7])
      else $error("first bit is not status msb");

   exact_count_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      sel_rise && fcnt_r != 5'h10 |=> !reg_wr_stb_o)
      else $error("write on bad bit count");

   parity_gate_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      frame_ok && !par_ok |=> !reg_wr_stb_o)
      else $error("write despite parity error");

   enable_once_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wd_en_r && !(sleep_mode_i && !sleep_d_r) |=> wd_en_r)
      else $error("watchdog enable cleared by software");

   sleep_clear_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      sleep_mode_i && !sleep_d_r |=> !wd_en_r)
      else $error("sleep did not clear enable");

   closed_kick_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wd_en_r && !stop_mode_i && wd_kick && wd_closed
      |=> watchdog_sysrst_o ##1 wd_cnt_r == 24'h000001)
      else $error("closed window restart not punished");

   stop_hold_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      stop_mode_i && stop_d_r && wd_en_r && !wd_kick
      |=> $stable(wd_cnt_r))
      else $error("timer ran in stop mode");
endmodule : adspi_port

//--- verification/adspi_master.sv
module adspi_master (
   output logic      sclk_o,
   output logic      sel_n_o,
   output logic      mosi_o,
   input  wire logic miso_i,
   input  wire logic miso_oe_n_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // serial master of the register port
   // ****************************************
   logic last_r;
   logic miso_wire;
   // a released data line shows the inverse of its last driven value
   always @(miso_i or miso_oe_n_i) begin
      if (miso_oe_n_i === 1'b0) last_r = miso_i;
   end
   assign miso_wire = (miso_oe_n_i === 1'b0) ? miso_i : ~last_r;
   // idle: clock and data pulled low, select pulled high
   initial begin
      last_r  = 1'b0;
      sclk_o  = 1'b0;
      sel_n_o = 1'b1;
      mosi_o  = 1'b0;
   end
   // one frame of n clocks, high phase 200 ns and low phase 120 ns
   task automatic xfer(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      // step off the system clock edge so no pin moves as it samples
      #1;
      sel_n_o = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         sclk_o = 1'b1;
         mosi_o = (i < 16) ? tx[15-i] : 1'b0;
         #200;
         sclk_o = 1'b0;
         rx = {rx[14:0], miso_wire};
         #120;
      end
      // select edge six system clocks clear of the last clock fall
      #120;
      sel_n_o = 1'b1;
      mosi_o  = 1'b0;
      // return on a system clock edge, select high five clocks
      #199;
   endtask : xfer
endmodule : adspi_master

//--- verification/adspi_port_test.sv
module adspi_port_test;
   import adspi_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // bench signals and monitors
   // ****************************************
   logic mclk_i, rst_i, sclk, sel_n, mosi, stop, sleep;
   logic [7:0] status, flags, cause;
   logic       miso, oe_n, stb, en, sysrst;
   logic [4:0] waddr;
   logic [7:0] wdata;
   logic [1:0] per;
   int         miscompares, tests_run, cyc, rst_cnt, rst_cyc, stb_cnt;
   int         stb_cyc, t0;
   adspi_port #(.WD_BASE_CYC(64)) i_adspi_port (
      .mclk_i(mclk_i), .rst_i(rst_i), .serial_shift_clock_i(sclk),
      .select_n_i(sel_n), .mosi_i(mosi), .system_status_i(status),
      .interrupt_flags_i(flags), .reset_cause_i(cause),
      .stop_mode_i(stop), .sleep_mode_i(sleep), .miso_o(miso),
      .miso_oe_n_o(oe_n), .reg_wr_stb_o(stb), .reg_wr_addr_o(waddr),
      .reg_wr_data_o(wdata), .watchdog_enable_once_o(en),
      .watchdog_period_select_o(per), .watchdog_sysrst_o(sysrst));
   adspi_master i_adspi_master (
      .sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi), .miso_i(miso),
      .miso_oe_n_i(oe_n));
   // clock
   always #20 mclk_i = ~mclk_i;
   // count cycles, write strobes and watchdog resets
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (sysrst === 1'b1) begin
         rst_cnt <= rst_cnt + 1;
         rst_cyc <= cyc;
      end
      if (stb === 1'b1) begin
         stb_cnt <= stb_cnt + 1;
         stb_cyc <= cyc;
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // direction, address, even parity (optionally spoiled), spare, data
   function automatic logic [15:0] word(logic rw, logic [4:0] a,
                                        logic [7:0] d, logic bad);
      return {rw, a, ^{rw, a} ^ bad, 1'b0, d};
   endfunction : word
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, logic bad);
      logic [15:0] rx;
      i_adspi_master.xfer(word(1'b1, a, 8'h5A, bad), 16, rx);
      chk(rx, {status, exp});
   endtask : rd
   task automatic wr(input logic [4:0] a, input logic [7:0] d,
                     input logic [7:0] old, input logic bad, input int n);
      logic [15:0] rx;
      int          s;
      s = stb_cnt;
      i_adspi_master.xfer(word(1'b0, a, d, bad), n, rx);
      repeat (12) @(posedge mclk_i);
      if (n == 16) chk(rx, {status, old});
      chk(16'(stb_cnt - s), (bad || n != 16) ? 16'h0000 : 16'h0001);
      if (!bad && n == 16) chk({3'h0, waddr, wdata}, {3'h0, a, d});
   endtask : wr
   task automatic wait_rst(input int lim);
      int n;
      n = rst_cnt;
      for (int i = 0; i < lim && rst_cnt == n; i++) @(posedge mclk_i);
   endtask : wait_rst
   // ****************************************
   // stimulus
   // ****************************************
   // cut a hang short
   initial begin
      #2ms;
      miscompares++;
      complete_run();
   end
   // main sequence
   initial begin
      {mclk_i, stop, sleep, cyc, rst_cnt, stb_cnt} = '0;
      {rst_cyc, stb_cyc, miscompares, tests_run} = '0;
      rst_i = 1'b1;
      {status, flags, cause} = {8'h5A, 8'h96, 8'h21};
      repeat (6) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      chk({oe_n, en, per}, 16'h0008);
      rd(ADR_WATCHDOG_CONTROL, 8'h00, 1'b0);
      wr(ADR_HALF_BRIDGE_OUT, 8'hA5, 8'h00, 1'b0, 16);
      rd(ADR_HALF_BRIDGE_OUT, 8'hA5, 1'b1);
      status = 8'hC3;
      wr(ADR_HALF_BRIDGE_OUT, 8'h3C, 8'hA5, 1'b0, 16);
      wr(ADR_HALF_BRIDGE_OUT, 8'h11, 8'h3C, 1'b1, 16);
      wr(ADR_HALF_BRIDGE_OUT, 8'h22, 8'h3C, 1'b0, 15);
      wr(ADR_HALF_BRIDGE_OUT, 8'h33, 8'h3C, 1'b0, 17);
      rd(ADR_HALF_BRIDGE_OUT, 8'h3C, 1'b0);
      rd(ADR_INTERRUPT_FLAGS, 8'h96, 1'b0);
      rd(ADR_RESET_CAUSE, 8'h21, 1'b0);
      rd(5'h05, 8'h00, 1'b0);
      wr(ADR_WATCHDOG_CONTROL, 8'h60, 8'h00, 1'b0, 16);
      chk({en, per}, 16'h0003);
      wr(ADR_WATCHDOG_CONTROL, 8'h80, 8'h60, 1'b0, 16);
      wr(ADR_WATCHDOG_CONTROL, 8'h00, 8'h80, 1'b0, 16);
      chk({en, per}, 16'h0004);
      wait_rst(1100);
      t0 = rst_cyc;
      wait_rst(600);
      chk(16'(rst_cyc - t0 >= 508 && rst_cyc - t0 <= 516), 16'h1);
      t0 = rst_cnt;
      wr(ADR_WATCHDOG_CONTROL, 8'h81, 8'h80, 1'b0, 16);
      chk(16'(rst_cnt - t0), 16'h1);
      chk(16'(rst_cyc - stb_cyc <= 8 && rst_cyc >= stb_cyc), 16'h1);
      repeat (200) @(posedge mclk_i);
      t0 = rst_cnt;
      wr(ADR_WATCHDOG_CONTROL, 8'h81, 8'h80, 1'b0, 16);
      repeat (400) @(posedge mclk_i);
      chk(16'(rst_cnt - t0), 16'h0);
      wait_rst(200);
      t0 = rst_cyc - stb_cyc;
      chk(16'(t0 >= 506 && t0 <= 520), 16'h1);
      #1 stop = 1'b1;
      t0 = rst_cnt;
      repeat (1000) @(posedge mclk_i);
      chk(16'(rst_cnt - t0), 16'h0);
      #1 stop = 1'b0;
      t0 = cyc;
      wait_rst(600);
      chk(16'(rst_cyc - t0 >= 508 && rst_cyc - t0 <= 520), 16'h1);
      #1 sleep = 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 sleep = 1'b0;
      repeat (2) @(posedge mclk_i);
      chk({15'h0, en}, 16'h0000);
      rd(ADR_WATCHDOG_CONTROL, 8'h00, 1'b0);
      // control register hides its mode request bits on read
      wr(ADR_SYSTEM_CONTROL, 8'hFF, 8'h00, 1'b0, 16);
      rd(ADR_SYSTEM_CONTROL, 8'h9F, 1'b0);
      // write-only register strobes out and reads back as zero
      wr(ADR_ANALOG_MUX_CTL, 8'h77, 8'h00, 1'b0, 16);
      rd(ADR_ANALOG_MUX_CTL, 8'h00, 1'b0);
      // the two middle period codes
      wr(ADR_WATCHDOG_CONTROL, 8'hA0, 8'h00, 1'b0, 16);
      wait_rst(600);
      t0 = rst_cyc;
      wait_rst(600);
      chk(16'(rst_cyc - t0 >= 252 && rst_cyc - t0 <= 260), 16'h1);
      wr(ADR_WATCHDOG_CONTROL, 8'hC0, 8'hA0, 1'b0, 16);
      wait_rst(600);
      t0 = rst_cyc;
      wait_rst(600);
      chk(16'(rst_cyc - t0 >= 124 && rst_cyc - t0 <= 132), 16'h1);
      complete_run();
   end
endmodule : adspi_port_test
